// File: verilog/shu_pkg.sv
// Shared constants and types for the serially hosted UART core.
// Assumes a single core clock domain; every pin is synchronised inside the core.
`default_nettype none
package shu_pkg;

  // ==========================================================================
  // Command codes carried in the first two bits of every frame.
  localparam logic [1:0] CMD_CFG_WR = 2'h3;
  localparam logic [1:0] CMD_CFG_RD = 2'h1;
  localparam logic [1:0] CMD_DAT_WR = 2'h2;
  localparam logic [1:0] CMD_DAT_RD = 2'h0;

  // ==========================================================================
  // Frame length on the host link, and the count at which replies are built.
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] REPLY_AT = 5'h02;

  // ==========================================================================
  // Field positions inside the 14 configuration bits.
  localparam int CFG_FIFO_OFF = 13;
  localparam int CFG_SHDN = 12;
  localparam int CFG_MASK_HI = 11;
  localparam int CFG_MASK_LO = 8;
  localparam int CFG_TXE_MASK = 11;
  localparam int CFG_RXR_MASK = 10;
  localparam int CFG_NINTH_MASK = 9;
  localparam int CFG_ACT_MASK = 8;
  localparam int CFG_IR = 7;
  localparam int CFG_ST = 6;
  localparam int CFG_PE = 5;
  localparam int CFG_WL = 4;
  localparam int CFG_BAUD_HI = 3;

  // ==========================================================================
  // Field positions of the transmit word and the test request.
  localparam int DAT_TX_INHIBIT = 10;
  localparam int DAT_RTS = 9;
  localparam int DAT_NINTH = 8;
  localparam int TEST_BIT = 0;

  // ==========================================================================
  // Reset values.
  localparam logic [13:0] CFG_RESET = 14'h0000;
  localparam logic RTS_RESET = 1'b0;

  // ==========================================================================
  // Oversampling: last phase of a bit and the three voting phases.
  localparam logic [3:0] PHASE_LAST = 4'hF;
  localparam logic [3:0] VOTE_FIRST = 4'h6;
  localparam logic [3:0] VOTE_MID = 4'h7;
  localparam logic [3:0] VOTE_LAST = 4'h8;

  // ==========================================================================
  // Receiver and transmitter states.
  typedef enum logic {RX_IDLE, RX_RUN} shu_rx_state_type;
  typedef enum logic {TX_IDLE, TX_SEND} shu_tx_state_type;

endpackage
`default_nettype wire

// File: verilog/shu_fifo.sv
// Receive word buffer with flush and a single-entry bypass mode.
// Assumes both sides run on core_clk; flush overrides a push in one cycle.
`timescale 1ns/1ns
`default_nettype none
module shu_fifo
  import shu_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic single,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  // Pointer width; the depth must be a power of two for pointer wrap.
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  // ==========================================================================
  // Elaboration check.
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_chk
    $error("shu_fifo: DEPTH must be a power of two of at least 2.");
  end

  // All storage and pointers of the buffer.
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } shu_fifo_state_type;

  shu_fifo_state_type s;
  shu_fifo_state_type next_s;
  logic do_push;
  logic do_pop;

  // Bypass mode holds at most one word, so it reports full after one.
  assign in_ready = single ? (s.cnt == '0) : (s.cnt != FULL_CNT);
  assign out_valid = (s.cnt != '0);
  assign out_data = s.mem[s.rp];

  // ==========================================================================
  // Next-state logic: flush wins over push and pop.
  always_comb
  begin
    next_s = s;
    do_push = in_valid && in_ready;
    do_pop = out_ready && out_valid;
    if (flush)
    begin
      next_s.wp = '0;
      next_s.rp = '0;
      next_s.cnt = '0;
    end
    else
    begin
      if (do_push)
      begin
        next_s.mem[s.wp] = in_data;
        next_s.wp = s.wp + AW'(1);
      end
      if (do_pop)
      begin
        next_s.rp = s.rp + AW'(1);
      end
      next_s.cnt = s.cnt + {AW'(0), do_push} - {AW'(0), do_pop};
    end
  end

  // State register.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

endmodule
`default_nettype wire

// File: verilog/shu_core.sv
// UART core controlled by a host over a 16-bit synchronous serial link.
// Assumes all pins are asynchronous to core_clk and are synchronised here.
// Notes on behaviour
// - Falling receive edge starts a character.
// - Sixteen samples per bit, vote of 7,8,9.
// - Eight-word receive buffer, flushed on overflow.
// - Sixteen bits; capture rising, drive falling.
// - Register actions happen at chip select rise.
// - First two bits select the command.
// - Short frame is dropped without any effect.
// - Each select fall starts a new frame.
// - Setup write clears buffer, flags and data.
// - Framing settings wait for idle transmitter.
// - Mask bits apply after sixteenth rising edge.
// - Setup read returns setup and status.
// - Test mode puts baud clock on rts while selected.
// - Test mode loops transmitter into receiver.
// - Inhibit bit suppresses load; rts still updates, word still pops.
// - Data read pops oldest received word.
// - Setup word layout; reply is status then zeros.
// - Data write also returns and pops word.
// - Data reply layout with inverted cts.
// - Empty reads zero; seven-bit top bit zero.
// - Buffer on when fifo_off clear, reset clear.
// - Baud select resets zero, reads back.
// - Rts bit resets zero, drives pin high.
// - rx_avail set while any word waits.
// - Word length and optional ninth bit.
`timescale 1ns/1ns
`default_nettype none
module shu_core
  import shu_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int DIV_W = 16,
  parameter int BAUD_BASE = 4
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic dout_oe_n,
  input wire logic rx,
  output logic tx,
  input wire logic cts_n,
  output logic rts_n,
  output logic irq_out,
  output logic irq_oe_n
);

  // ==========================================================================
  // Elaboration check: the baud level needs at least two cycles per tick.
  if (BAUD_BASE < 2 || BAUD_BASE * 16 >= (1 << DIV_W))
  begin : g_chk
    $error("shu_core: BAUD_BASE out of range for DIV_W.");
  end

  // Whole state of the core.
  typedef struct packed {
    logic [2:0] cs_sync;
    logic [2:0] sclk_sync;
    logic [1:0] din_sync;
    logic [1:0] rx_sync;
    logic [1:0] cts_sync;
    logic [4:0] bit_cnt;
    logic [15:0] in_sr;
    logic [15:0] out_sr;
    logic dout;
    logic [13:0] cfg_shadow;
    logic [13:0] cfg_active;
    logic cfg_pend;
    logic test_mode;
    logic rts_bit;
    logic rts_n;
    logic irq_oe_n;
    logic tx_empty;
    logic afe;
    logic [DIV_W-1:0] div_cnt;
    shu_rx_state_type rx_state;
    logic rx_prev;
    logic [3:0] rx_ph;
    logic [3:0] rx_idx;
    logic [1:0] rx_votes;
    logic [8:0] rx_word;
    shu_tx_state_type tx_state;
    logic txb_full;
    logic [7:0] txb_byte;
    logic txb_ninth;
    logic [3:0] tx_ph;
    logic [3:0] tx_left;
    logic [11:0] tx_frame;
    logic tx;
  } shu_state_type;

  shu_state_type s;
  shu_state_type next_s;

  // Buffer handshake; push, pop and flush come from the next-state logic, push_data from the received word, the rest from the buffer.
  logic push;
  logic pop;
  logic flush;
  logic fifo_ready;
  logic fifo_valid;
  logic [8:0] fifo_data;
  logic [8:0] push_data;

  // ==========================================================================
  // Helpers used by both receiver and transmitter, or by divider and rts.
  function automatic logic [3:0] shu_char_bits(input logic [13:0] cfg);
    return cfg[CFG_WL] ? 4'h7 + {3'h0, cfg[CFG_PE]}
                       : 4'h8 + {3'h0, cfg[CFG_PE]};
  endfunction

  function automatic logic [DIV_W-1:0] shu_div_limit(input logic [3:0] sel);
    return DIV_W'(BAUD_BASE * (int'(sel) + 1) - 1);
  endfunction

  // Edges and levels seen through the synchronisers.
  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic commit;
  logic [1:0] cmd;
  logic rx_src;
  logic tick;
  logic tx_idle;
  logic [13:0] reply;
  logic [8:0] head;

  assign cs_low = !s.cs_sync[1];
  assign cs_fall = !s.cs_sync[1] && s.cs_sync[2];
  assign cs_rise = s.cs_sync[1] && !s.cs_sync[2];
  assign sclk_rise = s.sclk_sync[1] && !s.sclk_sync[2];
  assign sclk_fall = !s.sclk_sync[1] && s.sclk_sync[2];
  // Only a full frame may act, and only at the select rise.
  assign commit = cs_rise && (s.bit_cnt == FRAME_BITS);
  assign cmd = s.in_sr[15:14];
  // In test mode the receiver listens to the transmitter.
  assign rx_src = s.test_mode ? s.tx : s.rx_sync[1];
  assign tick = (s.div_cnt >= shu_div_limit(s.cfg_active[CFG_BAUD_HI:0]));
  assign tx_idle = (s.tx_state == TX_IDLE) && !s.txb_full;

  // Head word, zero when nothing waits; seven-bit words clear bit 7.
  assign head = fifo_valid ? {fifo_data[8],
    fifo_data[7] & !s.cfg_shadow[CFG_WL], fifo_data[6:0]} : 9'h000;
  // Reply bits 13 down to 0 by command.
  always_comb
  begin
    case (s.in_sr[1:0])
      CMD_CFG_RD: reply = {s.cfg_shadow[CFG_FIFO_OFF], s.cfg_active[CFG_SHDN],
                           s.cfg_shadow[11:0]};
      CMD_CFG_WR: reply = 14'h0000;
      default: reply = {3'h0, s.afe, !s.cts_sync[1], head};
    endcase
  end

  // Received word as stored: ninth bit is zero without parity.
  assign push_data = {s.cfg_active[CFG_PE] & (s.cfg_active[CFG_WL] ?
    s.rx_word[7] : s.rx_word[8]), s.rx_word[7] & !s.cfg_active[CFG_WL],
    s.rx_word[6:0]};

  // ==========================================================================
  // Next-state logic: link, commit, baud, transmitter, receiver.
  always_comb
  begin
    logic [2:0] votes;
    logic maj;
    logic [3:0] nb;
    votes = {s.rx_votes, rx_src};
    maj = (votes[0] & votes[1]) | (votes[0] & votes[2]) | (votes[1] & votes[2]);
    nb = shu_char_bits(s.cfg_active);
    next_s = s;
    push = 1'b0;
    pop = 1'b0;
    flush = 1'b0;
    // Two-stage synchronisers; stage 0 feeds only stage 1.
    next_s.cs_sync = {s.cs_sync[1:0], cs_n};
    next_s.sclk_sync = {s.sclk_sync[1:0], sclk};
    next_s.din_sync = {s.din_sync[0], din};
    next_s.rx_sync = {s.rx_sync[0], rx};
    next_s.cts_sync = {s.cts_sync[0], cts_n};

    // Host link: restart on select fall, shift while selected.
    if (cs_fall)
    begin
      next_s.bit_cnt = 5'h00;
      next_s.out_sr = {fifo_valid, s.tx_empty, 14'h0000};
      next_s.dout = fifo_valid;
    end
    else if (cs_low)
    begin
      // Capture on the rising edge, at most sixteen bits.
      if (sclk_rise && s.bit_cnt != FRAME_BITS)
      begin
        next_s.in_sr = {s.in_sr[14:0], s.din_sync[1]};
        next_s.bit_cnt = s.bit_cnt + 5'h01;
        // Mask bits take effect on the sixteenth rising edge.
        if (s.bit_cnt == FRAME_BITS - 5'h01 && s.in_sr[14:13] == CMD_CFG_WR)
        begin
          next_s.cfg_shadow[CFG_MASK_HI:CFG_MASK_LO] = s.in_sr[10:7];
        end
      end
      // Drive on the falling edge; the reply is built once the command is in.
      if (sclk_fall)
      begin
        if (s.bit_cnt == REPLY_AT)
        begin
          next_s.out_sr = {reply, 2'h0};
          next_s.dout = reply[13];
        end
        else
        begin
          next_s.out_sr = {s.out_sr[14:0], 1'b0};
          next_s.dout = s.out_sr[14];
        end
      end
    end

    // Commit of a complete frame at chip select rise.
    if (commit)
    begin
      case (cmd)
        CMD_CFG_WR:
        begin
          // Rts and cts stay as they are.
          next_s.cfg_shadow = s.in_sr[13:0];
          next_s.cfg_pend = 1'b1;
          flush = 1'b1;
          next_s.tx_empty = 1'b0;
          next_s.afe = 1'b0;
          next_s.txb_full = 1'b0;
          next_s.txb_byte = 8'h00;
          next_s.txb_ninth = 1'b0;
        end
        CMD_CFG_RD:
        begin
          next_s.test_mode = s.in_sr[TEST_BIT];
        end
        CMD_DAT_WR:
        begin
          pop = fifo_valid;
          next_s.rts_bit = s.in_sr[DAT_RTS];
          if (!s.in_sr[DAT_TX_INHIBIT])
          begin
            next_s.txb_full = 1'b1;
            next_s.txb_byte = s.in_sr[7:0];
            next_s.txb_ninth = s.in_sr[DAT_NINTH];
            next_s.tx_empty = 1'b0;
          end
        end
        default:
        begin
          pop = fifo_valid;
        end
      endcase
    end

    // Held-back framing settings apply once the transmitter is idle.
    // A setup write committed in this same cycle keeps its own pending copy.
    if (s.cfg_pend && tx_idle && !(commit && cmd == CMD_CFG_WR))
    begin
      next_s.cfg_active = s.cfg_shadow;
      next_s.cfg_pend = 1'b0;
    end

    // Baud divider: one tick per sixteenth of a bit.
    next_s.div_cnt = tick ? '0 : s.div_cnt + DIV_W'(1);

    // Rts pin: baud clock in test mode while selected, else inverted bit.
    if (s.test_mode && cs_low)
    begin
      next_s.rts_n = (s.div_cnt <=
        (shu_div_limit(s.cfg_active[CFG_BAUD_HI:0]) >> 1));
    end
    else
    begin
      next_s.rts_n = !s.rts_bit;
    end

    // Transmitter: move the buffer into the shifter, then send bit by bit.
    case (s.tx_state)
      TX_IDLE:
      begin
        if (s.txb_full)
        begin
          // Stop levels above the byte, start bit below it.
          next_s.tx_frame = {3'h7, s.txb_byte, 1'b0};
          if (s.cfg_active[CFG_WL])
          begin
            next_s.tx_frame[8] = !s.cfg_active[CFG_PE] | s.txb_ninth;
          end
          else
          begin
            next_s.tx_frame[9] = !s.cfg_active[CFG_PE] | s.txb_ninth;
          end
          next_s.tx_left = nb + 4'h2 + {3'h0, s.cfg_active[CFG_ST]};
          next_s.tx_ph = 4'h0;
          next_s.tx = 1'b0;
          next_s.txb_full = 1'b0;
          next_s.tx_empty = 1'b1;
          next_s.tx_state = TX_SEND;
        end
      end
      default:
      begin
        if (tick)
        begin
          next_s.tx_ph = s.tx_ph + 4'h1;
          if (s.tx_ph == PHASE_LAST)
          begin
            if (s.tx_left == 4'h1)
            begin
              next_s.tx = 1'b1;
              next_s.tx_state = TX_IDLE;
            end
            else
            begin
              next_s.tx_frame = {1'b1, s.tx_frame[11:1]};
              next_s.tx = s.tx_frame[1];
              next_s.tx_left = s.tx_left - 4'h1;
            end
          end
        end
      end
    endcase

    // Receiver: edge-detected start, majority vote of three samples.
    next_s.rx_prev = rx_src;
    case (s.rx_state)
      RX_IDLE:
      begin
        if (s.rx_prev && !rx_src)
        begin
          next_s.rx_state = RX_RUN;
          next_s.rx_ph = 4'h0;
          next_s.rx_idx = 4'h0;
          next_s.rx_word = 9'h000;
        end
      end
      default:
      begin
        if (tick)
        begin
          next_s.rx_ph = s.rx_ph + 4'h1;
          if (s.rx_ph == VOTE_FIRST || s.rx_ph == VOTE_MID)
          begin
            next_s.rx_votes = votes[1:0];
          end
          if (s.rx_ph == PHASE_LAST)
          begin
            next_s.rx_idx = s.rx_idx + 4'h1;
          end
          if (s.rx_ph == VOTE_LAST)
          begin
            // Decide the bit from samples 7, 8 and 9.
            if (s.rx_idx == 4'h0)
            begin
              if (maj)
              begin
                next_s.rx_state = RX_IDLE;
              end
            end
            else if (s.rx_idx <= nb)
            begin
              next_s.rx_word[s.rx_idx - 4'h1] = maj;
            end
            else
            begin
              // Stop bit: a low level is a framing error; set beats clear.
              if (!maj)
              begin
                next_s.afe = 1'b1;
              end
              push = 1'b1;
              if (!fifo_ready)
              begin
                flush = 1'b1;
              end
              next_s.rx_state = RX_IDLE;
            end
          end
        end
      end
    endcase

    // Interrupt pin pulls low while an unmasked source is active.
    next_s.irq_oe_n = !((s.cfg_shadow[CFG_RXR_MASK] & fifo_valid) |
      (s.cfg_shadow[CFG_TXE_MASK] & s.tx_empty) |
      (s.cfg_shadow[CFG_NINTH_MASK] & head[8]) |
      (s.cfg_shadow[CFG_ACT_MASK] & s.afe));
  end

  // ==========================================================================
  // State register; idle lines and deselected link after reset.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.cs_sync <= 3'h7;
      s.rx_sync <= 2'h3;
      s.cts_sync <= 2'h3;
      s.rx_prev <= 1'b1;
      s.cfg_shadow <= CFG_RESET;
      s.cfg_active <= CFG_RESET;
      s.rts_bit <= RTS_RESET;
      s.rts_n <= 1'b1;
      s.irq_oe_n <= 1'b1;
      s.tx <= 1'b1;
      s.tx_frame <= 12'hFFF;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Receive buffer; bypassed to one entry when fifo_off is set.
  shu_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .flush(flush),
    .single(s.cfg_active[CFG_FIFO_OFF]),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(push_data),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  // Outputs, all from flip-flops except irq_out, which is tied low.
  assign dout = s.dout;
  assign dout_oe_n = s.cs_sync[1];
  assign tx = s.tx;
  assign rts_n = s.rts_n;
  assign irq_out = 1'b0;
  assign irq_oe_n = s.irq_oe_n;

  // ==========================================================================
  // Checks on the logic above.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  short_abort_a: assert property (cs_rise && !commit |=>
    $stable(s.cfg_shadow) && $stable(s.rts_bit) && $stable(s.test_mode))
    else $error("Short frame changed a register.");
  cfg_clear_a: assert property (commit && cmd == CMD_CFG_WR |=>
    !fifo_valid && !s.txb_full && s.cfg_pend)
    else $error("Setup write did not clear state.");
  mask_early_a: assert property (cs_low && !cs_fall && sclk_rise &&
    s.bit_cnt == 5'h0F && s.in_sr[14:13] == CMD_CFG_WR |=>
    s.cfg_shadow[11:8] == $past(s.in_sr[10:7]))
    else $error("Masks not taken at sixteenth edge.");
  cfg_hold_a: assert property (s.cfg_pend && !tx_idle |=>
    $stable(s.cfg_active))
    else $error("Settings applied while transmitting.");
  rts_level_a: assert property (!s.test_mode ##1 !s.test_mode |->
    s.rts_n == !$past(s.rts_bit))
    else $error("Rts pin does not follow rts bit.");
  start_edge_a: assert property (s.rx_state == RX_IDLE && s.rx_prev &&
    !rx_src |=> s.rx_state == RX_RUN && s.rx_ph == 4'h0)
    else $error("Start edge missed.");
  overflow_a: assert property (push && !fifo_ready |=> !fifo_valid)
    else $error("Overflow did not empty the buffer.");
  status_snap_a: assert property (cs_fall |=>
    s.dout == $past(fifo_valid) && s.out_sr[14] == $past(s.tx_empty))
    else $error("Status not captured at select fall.");
  inhibit_a: assert property (commit && cmd == CMD_DAT_WR &&
    s.in_sr[DAT_TX_INHIBIT] |=> $stable(s.txb_byte) &&
    s.rts_bit == $past(s.in_sr[DAT_RTS]))
    else $error("Inhibited write loaded data.");
  pop_read_a: assert property (commit && !cmd[1] && !cmd[0] &&
    fifo_valid |-> pop)
    else $error("Data read did not pop.");
  loop_rx_a: assert property (s.test_mode && $stable(s.test_mode) |->
    s.rx_prev == $past(s.tx))
    else $error("Loopback not in effect.");

  cfg_write_c: cover property (commit && cmd == CMD_CFG_WR);
  rx_push_c: cover property (push && fifo_ready);
  overflow_c: cover property (push && !fifo_ready);
  test_rts_c: cover property (s.test_mode && cs_low && $rose(s.rts_n));

endmodule
`default_nettype wire

// File: sim/shu_host.sv
// Host model: serial bus master framing 16-bit words for the core.
// Assumes core_clk runs free; pins change on its falling edge.
`timescale 1ns/1ns
`default_nettype none
module shu_host
(
  input wire logic core_clk,
  output logic cs_n,
  output logic sclk,
  input wire logic dout,
  output logic din
);
  // Deselected and clock standing still between frames.
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end

  // One frame, command bits first; fewer than 16 bits aborts it.
  task automatic xfer(input logic [15:0] w, input int n,
                      output logic [15:0] r);
    r = 16'h0000;
    @(negedge core_clk) cs_n = 1'b0;
    repeat (8) @(negedge core_clk);
    for (int i = 0; i < n; i++)
    begin
      sclk = 1'b0;
      din = w[15-i];
      repeat (4) @(negedge core_clk);
      r[15-i] = dout;
      sclk = 1'b1;
      repeat (4) @(negedge core_clk);
    end
    sclk = 1'b0;
    repeat (4) @(negedge core_clk);
    cs_n = 1'b1;
    din = ~din; // Released line shows no stale value.
    repeat (8) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

// File: sim/shu_core_tb.sv
// Self-checking bench for the serially hosted UART core.
// Assumes default parameters: one bit lasts 64 core_clk cycles.
`timescale 1ns/1ns
`default_nettype none
module shu_core_tb;
  import shu_pkg::*;
  localparam int BIT = 64; // Sixteen ticks of four cycles.
  logic core_clk, rst_n, cs_n, sclk, din, dout, dout_oe_n;
  logic rx, tx, cts_n, rts_n, irq_out, irq_oe_n;
  logic [15:0] r;
  int failures, samples_checked, cycles;

  shu_core dut_u (.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n),
    .sclk(sclk), .din(din), .dout(dout), .dout_oe_n(dout_oe_n),
    .rx(rx), .tx(tx), .cts_n(cts_n), .rts_n(rts_n),
    .irq_out(irq_out), .irq_oe_n(irq_oe_n));
  // A deselected output shows the inverse of its last value to the host.
  shu_host host_u (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk),
    .dout(dout_oe_n ? !dout : dout), .din(din));

  // Free-running 100 MHz clock.
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Compares one reply word and counts it.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
      begin
        failures++;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
  endtask

  // Sends one 8-bit character on the receive line, LSB first.
  task automatic send_rx(input logic [7:0] b);
    @(negedge core_clk) rx = 1'b0;
    repeat (BIT) @(negedge core_clk);
    for (int i = 0; i < 8; i++)
    begin
      rx = b[i];
      repeat (BIT) @(negedge core_clk);
    end
    rx = 1'b1;
    repeat (BIT + 8) @(negedge core_clk);
  endtask

  // Power-up readback and pin levels.
  task automatic t_reset();
    host_u.xfer(16'h4000, 16, r);
    chk(r, 16'h0000);
    chk({15'h0000, rts_n}, 16'h0001);
    chk({14'h0000, dout_oe_n, irq_oe_n}, 16'h0003);
  endtask

  // Setup write, readback, and an aborted short frame.
  task automatic t_cfg();
    host_u.xfer(16'hC393, 16, r);
    chk(r, 16'h0000);
    host_u.xfer(16'h4000, 16, r);
    chk(r, 16'h0393);
    host_u.xfer(16'hC000, 10, r);
    host_u.xfer(16'h4000, 16, r);
    chk(r, 16'h0393);
    // Leaves only the receive mask set for the scenarios that follow.
    host_u.xfer(16'hC400, 16, r);
    chk(r, 16'h0000);
  endtask

  // One received character, then an empty read.
  task automatic t_rx();
    cts_n = 1'b0;
    send_rx(8'hA5);
    chk({14'h0000, irq_out, irq_oe_n}, 16'h0000);
    host_u.xfer(16'h0000, 16, r);
    chk(r, 16'h82A5);
    chk({14'h0000, irq_out, irq_oe_n}, 16'h0001);
    host_u.xfer(16'h0000, 16, r);
    chk(r, 16'h0200);
    cts_n = 1'b1;
  endtask

  // Oldest word first, then overflow empties the buffer.
  task automatic t_fifo();
    for (int k = 1; k <= 8; k++)
      send_rx(k[7:0]);
    host_u.xfer(16'h0000, 16, r);
    chk(r, 16'h8001);
    send_rx(8'h09);
    send_rx(8'h0A);
    host_u.xfer(16'h0000, 16, r);
    chk(r, 16'h0000);
  endtask

  // Test-mode loopback, and an inhibited write that moves rts and pops the looped word.
  task automatic t_loop();
    host_u.xfer(16'h4001, 16, r);
    host_u.xfer(16'h803C, 16, r);
    chk(r, 16'h0000);
    repeat (900) @(negedge core_clk);
    host_u.xfer(16'h86FF, 16, r);
    chk(r, 16'hC03C);
    chk({15'h0000, rts_n}, 16'h0000);
    repeat (900) @(negedge core_clk);
    host_u.xfer(16'h4000, 16, r);
    chk(r, 16'h4400);
  endtask

  // Prints the verdict and ends the run.
  task automatic results();
    if (failures == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Cuts a hang short.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 60000)
      begin
        failures++;
        results();
      end
  end

  // Main sequence.
  initial
  begin
    rst_n = 1'b0;
    rx = 1'b1;
    cts_n = 1'b1;
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    t_reset();
    t_cfg();
    t_rx();
    t_fifo();
    t_loop();
    results();
  end
endmodule
`default_nettype wire
